/* File: src/char_lcd_host.sv */
// What this block does
// - select pin picks data buffer or command latch
// - read/write pin high reads, low writes
// - 8-bit mode uses all eight lines
// - high four lines carry nibbles in 4-bit
// - select low, write: instruction to latch
// - select high, write: byte to data buffer
// - select high, read: byte from data buffer
// - host polls busy zero before next write
`timescale 1ns/1ps
`include "char_lcd_cfg.svh"

module char_lcd_host
   import char_lcd_pkg::*;
(
   input  wire  logic       clock,
   input  wire  logic       rst,
   input  wire  lcd_req_t   req,
   input  wire  logic       req_valid,
   input  wire  logic       bus_8bit,
   output logic             req_ready,
   output logic             rsp_valid,
   output logic [7:0]       rsp_data,
   output logic             reg_select_pin,
   output logic             rw_select_pin,
   output logic             strobe_pin,
   input  wire  logic [7:0] bus_in,
   output logic [7:0]       bus_out,
   output logic             bus_oe_low,
   output logic             bus_oe_high
);

   lcd_state_t       state_r, state_nxt;
   logic [`CNT_W-1:0] cnt_r, cnt_nxt;
   lcd_req_t         cur_r;
   logic             mode8_r;
   logic             polling_r, polling_nxt;
   logic             second_r, second_nxt;
   logic [7:0]       rd_r, rd_nxt;
   logic [7:0]       sync1_r, sync2_r;
   logic             ready_nxt, rsp_valid_nxt;
   logic [7:0]       rsp_data_nxt;

   // phase decode
   wire accept     = (state_r == ST_IDLE) && req_valid;
   // pins settle a clock after entry, so setup counts one more
   wire su_done    = cnt_r == `CNT_W'(`SU_CYC);
   wire high_done  = cnt_r == `CNT_W'(`TW_CYC - 1);
   wire low_done   = cnt_r == `CNT_W'(`LOW_CYC - 1);
   wire last_half  = mode8_r || second_r;
   // while polling, the pins carry a status read, not the order
   wire act_rs     = polling_r ? 1'b0 : cur_r.reg_select;
   wire act_rw     = polling_r ? 1'b1 : cur_r.read;
   wire writing    = !act_rw;
   // high nibble goes first in 4-bit mode
   wire [3:0] wr_nib   = second_r ? cur_r.data[3:0] : cur_r.data[7:4];
   wire [7:0] wr_lines = mode8_r ? cur_r.data : {wr_nib, 4'h0};
   wire [7:0] sampled  = mode8_r ? sync2_r
                       : (second_r ? {rd_r[7:4], sync2_r[7:4]}
                                   : {sync2_r[7:4], rd_r[3:0]});
   wire busy_seen   = rd_r[`TOP_BUS_LINE];
   wire in_frame    = (state_r != ST_IDLE);

   always_comb begin
      state_nxt     = state_r;
      cnt_nxt       = cnt_r + `CNT_W'(1);
      polling_nxt   = polling_r;
      second_nxt    = second_r;
      rd_nxt        = rd_r;
      ready_nxt     = req_ready;
      rsp_valid_nxt = 1'b0;
      rsp_data_nxt  = rsp_data;
      case (state_r)
         ST_IDLE: begin
            cnt_nxt = '0;
            if (req_valid) begin
               // every write waits for busy low first
               polling_nxt = !req.read;
               second_nxt  = 1'b0;
               ready_nxt   = 1'b0;
               state_nxt   = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (su_done) begin
               cnt_nxt   = '0;
               state_nxt = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (high_done) begin
               // sync delay is far below tw minus output delay
               if (!writing) begin
                  rd_nxt = sampled;
               end
               cnt_nxt   = '0;
               state_nxt = ST_LOW;
            end
         end
         ST_LOW: begin
            if (low_done) begin
               cnt_nxt   = '0;
               state_nxt = ST_SETUP;
               if (!last_half) begin
                  second_nxt = 1'b1;
               end else begin
                  second_nxt = 1'b0;
                  if (polling_r) begin
                     // busy keeps the poll going, else issue order
                     polling_nxt = busy_seen;
                  end else begin
                     state_nxt     = ST_IDLE;
                     ready_nxt     = 1'b1;
                     rsp_valid_nxt = cur_r.read;
                     rsp_data_nxt  = rd_r;
                  end
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            ready_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r   <= ST_IDLE;
         cnt_r     <= '0;
         polling_r <= 1'b0;
         second_r  <= 1'b0;
         rd_r      <= 8'h00;
         req_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_data  <= 8'h00;
      end else begin
         state_r   <= state_nxt;
         cnt_r     <= cnt_nxt;
         polling_r <= polling_nxt;
         second_r  <= second_nxt;
         rd_r      <= rd_nxt;
         req_ready <= ready_nxt;
         rsp_valid <= rsp_valid_nxt;
         rsp_data  <= rsp_data_nxt;
      end
   end

   // order and bus width held for the whole transfer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cur_r   <= '0;
         mode8_r <= 1'b1;
      end else if (accept) begin
         cur_r   <= req;
         mode8_r <= bus_8bit;
      end
   end

   // bus lines come from the far side
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
      end else begin
         sync1_r <= bus_in;
         sync2_r <= sync1_r;
      end
   end

   // pins registered; select and data stay through the low phase
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_select_pin <= 1'b0;
         rw_select_pin  <= 1'b1;
         strobe_pin     <= 1'b0;
         bus_out        <= 8'h00;
         bus_oe_high    <= 1'b0;
         bus_oe_low     <= 1'b0;
      end else begin
         reg_select_pin <= in_frame ? act_rs : reg_select_pin;
         rw_select_pin  <= in_frame ? act_rw : 1'b1;
         strobe_pin     <= (state_nxt == ST_HIGH);
         bus_out        <= wr_lines;
         bus_oe_high    <= in_frame && writing && (state_nxt != ST_IDLE);
         // open in 4-bit mode
         bus_oe_low     <= in_frame && writing && mode8_r
                           && (state_nxt != ST_IDLE);
      end
   end

   // helper: length of the current strobe high phase
   logic [`CNT_W-1:0] e_len_r;
   logic              busy_ok_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         e_len_r   <= '0;
         busy_ok_r <= 1'b0;
      end else begin
         e_len_r <= strobe_pin ? e_len_r + `CNT_W'(1) : '0;
         if (state_r == ST_LOW && low_done && last_half && polling_r)
            busy_ok_r <= !busy_seen;
         else if (accept)
            busy_ok_r <= 1'b0;
      end
   end

   a_sel_setup: assert property (@(posedge clock) disable iff (rst)
      $rose(strobe_pin) |-> $past(reg_select_pin, 10) == reg_select_pin
                            && $past(rw_select_pin, 10) == rw_select_pin)
      else $error("select changed inside setup time");

   a_sel_stable: assert property (@(posedge clock) disable iff (rst)
      strobe_pin |-> $stable(reg_select_pin) && $stable(rw_select_pin))
      else $error("select moved while strobe high");

   a_read_release: assert property (@(posedge clock) disable iff (rst)
      rw_select_pin |-> !bus_oe_high && !bus_oe_low)
      else $error("host drives bus during read");

   a_write_drive: assert property (@(posedge clock) disable iff (rst)
      (strobe_pin && !rw_select_pin) |-> bus_oe_high ##1 bus_oe_high)
      else $error("write data not held across falling strobe");

   a_low_open: assert property (@(posedge clock) disable iff (rst)
      !mode8_r |-> !bus_oe_low)
      else $error("low lines driven in 4-bit mode");

   a_pulse_width: assert property (@(posedge clock) disable iff (rst)
      $fell(strobe_pin) |-> $past(e_len_r) == `CNT_W'(`TW_CYC - 1))
      else $error("strobe high width wrong");

   a_nibble_order: assert property (@(posedge clock) disable iff (rst)
      (strobe_pin && !mode8_r && !rw_select_pin)
         |-> bus_out[7:4] == (second_r ? cur_r.data[3:0]
                                       : cur_r.data[7:4]))
      else $error("nibble order wrong");

   a_poll_first: assert property (@(posedge clock) disable iff (rst)
      ($rose(strobe_pin) && !rw_select_pin) |-> busy_ok_r)
      else $error("write issued without busy low");

   a_rsp_done: assert property (@(posedge clock) disable iff (rst)
      rsp_valid |-> req_ready && !strobe_pin && $past(state_r) == ST_LOW)
      else $error("response outside transfer end");

endmodule

/* File: src/char_lcd_cfg.svh */
`ifndef CHAR_LCD_CFG_SVH
`define CHAR_LCD_CFG_SVH

// clock period and bus timing, in ns
`define CLK_NS       4
`define TSU_NS       40
`define TW_NS        230
`define TC_NS        500
`define TDELAY_NS    120

// least times round up to whole clock cycles
`define SU_CYC  (((`TSU_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define TW_CYC  (((`TW_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define TC_CYC  (((`TC_NS) + (`CLK_NS) - 1) / (`CLK_NS))
// low phase also covers tw low, hold and the remainder of tc
`define LOW_CYC ((`TC_CYC) - (`TW_CYC))

// status byte layout and counter width
`define TOP_BUS_LINE 7
`define CNT_W        8

`endif

/* File: src/char_lcd_pkg.sv */
package char_lcd_pkg;

   typedef struct packed {
      logic       reg_select;
      logic       read;
      logic [7:0] data;
   } lcd_req_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_HIGH,
      ST_LOW
   } lcd_state_t;

endpackage

/* File: tb/lcd_dev_model.sv */
`timescale 1ns/1ps
module lcd_dev_model (
   input  wire logic       clock,
   input  wire logic       m8,
   input  wire logic       sel,
   input  wire logic       rw,
   input  wire logic       stb,
   input  wire logic [7:0] hout,
   input  wire logic       oel,
   input  wire logic       oeh,
   output logic      [7:0] lines,
   output int              viol
);
   logic [7:0] mem [128];
   logic [7:0] dbuf = 8'h00, drv = 8'h00, last = 8'h00, b, cur;
   logic [6:0] ap = 7'h00;
   logic [3:0] hi = 4'h0;
   logic       prev = 1'b0, lo = 1'b0, slow = 1'b0, drive;
   int         busy = 0, wt = 0, nviol = 0;
   assign viol = nviol;
   initial foreach (mem[i]) mem[i] = 8'h00;
   assign cur = sel ? dbuf : {busy > 0, ap};
   // slow answers come 28 clocks late, inside the 30 allowed
   assign drive = stb && rw && wt == 0;
   assign b = m8 ? lines : {hi, lines[7:4]};
   // released lines toggle, so stale data never looks valid
   always_comb begin
      lines[7:4] = oeh ? hout[7:4] : drive ? drv[7:4] : ~last[7:4];
      lines[3:0] = oel ? hout[3:0] : (drive && m8) ? drv[3:0]
                 : ~last[3:0];
   end
   always @(posedge clock) begin
      prev <= stb;
      last <= lines;
      if (busy > 0) busy <= busy - 1;
      if (!stb) wt <= slow ? 28 : 0;
      else if (wt > 0) wt <= wt - 1;
      if ((stb && rw && (oel || oeh)) || (oel && !m8)) nviol <= nviol + 1;
      if (stb && !prev && !rw && busy > 0) nviol <= nviol + 1;
      if (stb && !prev) begin
         slow <= !slow;
         drv <= (m8 || !lo) ? cur : {cur[3:0], 4'h0};
      end
      if (!stb && prev) begin
         lo <= m8 ? 1'b0 : !lo;
         hi <= lines[7:4];
         if (m8 || lo) begin
            if (!rw) busy <= 200;
            if (!rw && !sel && b[7]) begin
               ap <= b[6:0];
               dbuf <= mem[b[6:0]];
            end
            if (!rw && sel) begin
               mem[ap] <= b;
               ap <= ap + 7'd1;
            end
            if (rw && sel) begin
               dbuf <= mem[ap + 7'd1];
               ap <= ap + 7'd1;
            end
         end
      end
   end
endmodule

/* File: tb/test_char_lcd_host.sv */
`timescale 1ns/1ps
module test_char_lcd_host;
   import char_lcd_pkg::*;
   logic       clock = 0, rst = 1, req_valid = 0, bus_8bit = 1;
   lcd_req_t   req = '0;
   logic       req_ready, rsp_valid, sel_pin, rw_pin, strobe_pin, oel, oeh;
   logic [7:0] rsp_data, bus_in, bus_out, addr;
   int         viol, n_errors = 0, checks = 0, seed = 371, ap = 0;
   int         mem [128];
   logic       last_wr = 0;
   always #2 clock = ~clock;
   char_lcd_host uut (
      .clock(clock), .rst(rst), .req(req), .req_valid(req_valid),
      .bus_8bit(bus_8bit), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .reg_select_pin(sel_pin),
      .rw_select_pin(rw_pin), .strobe_pin(strobe_pin), .bus_in(bus_in),
      .bus_out(bus_out), .bus_oe_low(oel), .bus_oe_high(oeh));
   lcd_dev_model dev (
      .clock(clock), .m8(bus_8bit), .sel(sel_pin), .rw(rw_pin),
      .stb(strobe_pin), .hout(bus_out), .oel(oel), .oeh(oeh),
      .lines(bus_in), .viol(viol));
   initial foreach (mem[i]) mem[i] = 0;
   task check(input string name, input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task stop_test;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // reference: busy only straight after a write
   task op(input logic sel, rd, input logic [7:0] data);
      logic [7:0] e;
      int         n;
      e = sel ? 8'(mem[ap]) : {last_wr, 7'(ap)};
      while (req_ready !== 1'b1) @(negedge clock);
      req = '{sel, rd, data};
      req_valid = 1;
      @(negedge clock);
      req_valid = 0;
      n = 0;
      while ((rd ? rsp_valid : req_ready) !== 1'b1 && n < 5000) begin
         @(negedge clock);
         n++;
      end
      if (n == 5000) n_errors++;
      if (rd) begin
         check("rsp_data", rsp_data, e);
         if (sel) ap = (ap + 1) % 128;
         last_wr = 0;
      end else begin
         if (sel) mem[ap] = int'(data);
         if (sel) ap = (ap + 1) % 128;
         else if (data[7]) ap = int'(data[6:0]);
         last_wr = 1;
      end
   endtask
   initial begin
      repeat (10) @(negedge clock);
      rst = 0;
      check("idle", {4'h0, req_ready, rsp_valid, strobe_pin, rw_pin},
            8'h09);
      for (int m = 1; m >= 0; m--) begin
         bus_8bit = m[0];
         addr = 8'($random(seed)) & 8'h3f;
         op(0, 0, 8'h06);
         op(0, 0, 8'h80 | addr);
         repeat (3) op(1, 0, 8'($random(seed)));
         op(0, 1, 8'h00);
         op(0, 0, 8'h80 | addr);
         repeat (3) op(1, 1, 8'h00);
         op(0, 1, 8'h00);
      end
      check("faults", {7'h00, viol != 0}, 8'h00);
      stop_test;
   end
   // whole run is near 8600 clocks
   initial begin
      #200000;
      n_errors++;
      stop_test;
   end
endmodule
